// ### pll_serial_control_lock_detect_tb_top.sv
`timescale 1ns/10ps
`include "pscl_defs.svh"
module pll_serial_control_lock_detect_tb_top;
  logic        i_core_clk;
  logic        i_rst;
  logic        i_chip_enable;
  logic        i_cmp_cycle;
  logic        i_pulse_in_window;
  logic        i_cycle_slip;
  logic        ser_clk;
  logic        ser_data;
  logic        load_strobe;
  logic        o_test_output;
  logic        o_test_readback;
  logic        o_lock_detect_pin;
  logic        o_power_down;
  logic        o_pump_tristate;
  logic        o_freq_change;
  logic        o_var_modulus;
  logic [15:0] o_int_value;
  logic [24:0] o_fraction_word;
  logic [23:0] o_aux_numerator;
  logic [23:0] o_aux_denominator;
  logic        o_half_step_cancel;
  logic [5:0]  o_ref_ratio;
  logic        o_ref_doubler;
  logic        o_ref_halver;
  logic [3:0]  o_pump_current;
  logic [11:0] o_resync_divider;
  logic [3:0]  o_lock_window;
  logic [31:0] rb;
  int          err_total;
  int          cmp_count;
  int          fc_cnt;
  localparam logic [31:0] r5_word = {3'b000, 4'hA, 1'b1, 1'b0, 1'b1, 1'b1,
                                     5'h05, 12'h321, 4'h5};

  pscl_top pscl_top_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_ser_clk(ser_clk), .i_ser_data(ser_data), .i_load_strobe(load_strobe),
    .i_chip_enable(i_chip_enable), .i_cmp_cycle(i_cmp_cycle),
    .i_pulse_in_window(i_pulse_in_window), .i_cycle_slip(i_cycle_slip),
    .o_test_output(o_test_output), .o_test_readback(o_test_readback),
    .o_lock_detect_pin(o_lock_detect_pin), .o_power_down(o_power_down),
    .o_pump_tristate(o_pump_tristate), .o_freq_change(o_freq_change),
    .o_var_modulus(o_var_modulus), .o_int_value(o_int_value),
    .o_fraction_word(o_fraction_word), .o_aux_numerator(o_aux_numerator),
    .o_aux_denominator(o_aux_denominator),
    .o_half_step_cancel(o_half_step_cancel), .o_ref_ratio(o_ref_ratio),
    .o_ref_doubler(o_ref_doubler), .o_ref_halver(o_ref_halver),
    .o_pump_current(o_pump_current), .o_resync_divider(o_resync_divider),
    .o_lock_window(o_lock_window));

  // Board ORs both test output flops onto the one pin
  pscl_host_model pscl_host_model_inst (.o_ser_clk(ser_clk),
    .o_ser_data(ser_data), .o_load_strobe(load_strobe),
    .i_readback(o_test_readback | o_test_output));

  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk) begin
    if (o_freq_change === 1'b1) begin
      fc_cnt++;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [31:0] w);
    pscl_host_model_inst.send(w, rb);
    repeat (4) @(posedge i_core_clk);
    #2;
  endtask

  task automatic cmp_pulse(input logic win, input logic slip, input int n);
    repeat (n) begin
      @(posedge i_core_clk);
      #2;
      i_cmp_cycle = 1'b1;
      i_pulse_in_window = win;
      i_cycle_slip = slip;
      @(posedge i_core_clk);
      #2;
      i_cmp_cycle = 1'b0;
    end
    repeat (2) @(posedge i_core_clk);
    #2;
  endtask

  task automatic t_buffered;
    int n;
    n = fc_cnt;
    wr(32'h1000_0011);
    wr(32'h0ABC_DEF3);
    wr(32'h0123_4564);
    wr(r5_word);
    chk(o_fraction_word, 0, "frac pending");
    chk(o_ref_ratio, 32, "ratio pending");
    chk(o_half_step_cancel, 1, "half step");
    chk(fc_cnt, n, "no change yet");
    wr({3'b000, 1'b1, 8'h00, 16'd100, 4'h0});
    chk(fc_cnt, n + 1, "one change");
    chk(o_var_modulus, 1, "var mod");
    chk(o_int_value, 100, "int");
    chk(o_fraction_word, 25'h100_0001, "frac");
    chk(o_aux_numerator, 24'hABCDEF, "aux num");
    chk(o_aux_denominator, 24'h123456, "aux den");
    chk({o_ref_doubler, o_ref_halver, o_ref_ratio}, 8'hC5, "ref");
    chk({o_pump_current, o_resync_divider}, 16'hA321, "cp resync");
    wr({3'b000, 1'b0, 8'h00, 16'd511, 4'h0});
    chk({o_var_modulus, o_int_value}, 17'h001FF, "fixed 511");
    $display("test buffered done");
  endtask

  task automatic t_select;
    int n;
    wr(32'h0000_0206);
    wr(32'h4000_0009);
    chk(o_lock_window, 4'b0110, "window");
    n = fc_cnt;
    wr(32'hC000_030E);
    wr(32'hC000_030F);
    chk(o_lock_window, 4'b0110, "ignored sel");
    chk(fc_cnt, n, "ignored commit");
    wr(32'hC000_030D);
    chk(o_lock_window, 4'b0110, "sel 13");
    $display("test select done");
  endtask

  task automatic t_lock;
    wr(32'h2000_000C);
    wr(32'h0400_0007);
    cmp_pulse(1'b1, 1'b0, 1);
    cmp_pulse(1'b0, 1'b0, 1);
    cmp_pulse(1'b1, 1'b0, 1);
    chk(o_lock_detect_pin, 0, "window miss");
    cmp_pulse(1'b1, 1'b0, 1);
    chk(o_lock_detect_pin, 1, "lock fast");
    chk(o_test_output, 1, "lock on pin");
    cmp_pulse(1'b1, 1'b1, 1);
    chk(o_lock_detect_pin, 0, "slip");
    chk(o_test_output, 0, "slip pin");
    wr(32'h0000_0007);
    cmp_pulse(1'b1, 1'b0, 32);
    chk(o_lock_detect_pin, 0, "slow one meas");
    cmp_pulse(1'b1, 1'b0, 32);
    chk(o_lock_detect_pin, 1, "slow lock");
    $display("test lock done");
  endtask

  task automatic t_readback;
    logic [31:0] sel_w [3];
    logic [31:0] exp_w [3];
    sel_w = '{32'h8001_400C, 32'h8003_800C, 32'h8003_C00C};
    exp_w = '{r5_word, `PSCL_REV_CODE, `PSCL_RB_PATTERN};
    for (int i = 0; i < 3; i++) begin
      wr(sel_w[i]);
      chk(o_test_output, 0, "mux low");
      pscl_host_model_inst.send(32'h0, rb);
      chk(rb, exp_w[i], "readback");
      repeat (4) @(posedge i_core_clk);
    end
    $display("test readback done");
  endtask

  task automatic t_disable;
    wr(32'h1000_000C);
    chk(o_test_output, 1, "mux high");
    i_chip_enable = 1'b0;
    repeat (4) @(posedge i_core_clk);
    #2;
    chk(o_test_output, 0, "pin grounded");
    chk({o_power_down, o_pump_tristate}, 2'b11, "powered down");
    i_chip_enable = 1'b1;
    repeat (4) @(posedge i_core_clk);
    #2;
    chk({o_test_output, o_lock_window}, 0, "regs lost");
    chk(o_power_down, 0, "powered up");
    $display("test disable done");
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    err_total++;
    give_verdict;
  end

  initial begin
    i_rst = 1'b1;
    i_chip_enable = 1'b1;
    i_cmp_cycle = 1'b0;
    i_pulse_in_window = 1'b0;
    i_cycle_slip = 1'b0;
    repeat (15) @(posedge i_core_clk);
    #2;
    chk({o_power_down, o_pump_tristate}, 2'b11, "reset pd");
    chk({o_ref_ratio, o_test_output, o_freq_change}, 8'h80, "reset out");
    @(posedge i_core_clk);
    #2;
    i_rst = 1'b0;
    repeat (4) @(posedge i_core_clk);
    #2;
    chk(o_power_down, 0, "running");
    t_buffered;
    t_select;
    t_lock;
    t_readback;
    t_disable;
    give_verdict;
  end
endmodule

// ### pscl_defs.svh
`ifndef PSCL_DEFS_SVH
`define PSCL_DEFS_SVH

// Register indices taken from the four select bits
`define PSCL_REG_INT       4'h0
`define PSCL_REG_FRAC      4'h1
`define PSCL_REG_AUXNUM    4'h3
`define PSCL_REG_AUXDEN    4'h4
`define PSCL_REG_REFDIV    4'h5
`define PSCL_REG_FUNC      4'h6
`define PSCL_REG_CLK2      4'h7
`define PSCL_REG_LDBIAS    4'h9
`define PSCL_REG_MUXRB     4'hC
`define PSCL_REG_LAST      4'hD
`define PSCL_REG_COUNT     14

// Field positions
`define PSCL_VARMOD_BIT    28
`define PSCL_INT_MSB       19
`define PSCL_INT_LSB       4
`define PSCL_FRAC_MSB      28
`define PSCL_FRAC_LSB      4
`define PSCL_AUX_MSB       27
`define PSCL_AUX_LSB       4
`define PSCL_HALFCANCEL    24
`define PSCL_CPI_MSB       28
`define PSCL_CPI_LSB       25
`define PSCL_HALVER_BIT    22
`define PSCL_DOUBLER_BIT   21
`define PSCL_RCNT_MSB      20
`define PSCL_RCNT_LSB      16
`define PSCL_RESYNC_MSB    15
`define PSCL_RESYNC_LSB    4
`define PSCL_WINSEL_MSB    9
`define PSCL_WINSEL_LSB    8
`define PSCL_WINBIAS_MSB   31
`define PSCL_WINBIAS_LSB   30
`define PSCL_LDCNT_MSB     29
`define PSCL_LDCNT_LSB     27
`define PSCL_LDRATE_BIT    26
`define PSCL_MUXSEL_MSB    31
`define PSCL_MUXSEL_LSB    28
`define PSCL_RBSEL_MSB     19
`define PSCL_RBSEL_LSB     14

// Reset values and fixed codes
`define PSCL_WORD_RESET    32'h0000_0000
`define PSCL_REV_CODE      32'h0000_0011
`define PSCL_RB_PATTERN    32'hA5A5_5A5A
`define PSCL_RB_REVSEL     6'h0E
`define PSCL_RB_PATSEL     6'h0F
`define PSCL_SLOW_DIV      5'h1F

`endif

// ### pscl_host_model.sv
`timescale 1ns/10ps
module pscl_host_model (
  output logic      o_ser_clk,
  output logic      o_ser_data,
  output logic      o_load_strobe,
  input  wire logic i_readback
);
  initial begin
    o_ser_clk     = 1'b0;
    o_ser_data    = 1'b0;
    o_load_strobe = 1'b1;
  end

  // One frame, clock idle low outside it; readback sampled 8 ns into the high phase
  task automatic send(input logic [31:0] w, output logic [31:0] rb);
    o_load_strobe = 1'b0;
    #40;
    for (int i = 31; i >= 0; i--) begin
      o_ser_data = w[i];
      #8 o_ser_clk = 1'b1;
      #8 rb[i] = i_readback;
      #16 o_ser_clk = 1'b0;
    end
    // Released line shows the inverse of its last level
    o_ser_data = ~w[0];
    #16 o_load_strobe = 1'b1;
    #200;
  endtask
endmodule

// ### pscl_pkg.sv
package pscl_pkg;

  typedef enum logic [3:0] {
    PSCL_MUX_LOW      = 4'b0000,
    PSCL_MUX_HIGH     = 4'b0001,
    PSCL_MUX_LOCK     = 4'b0010,
    PSCL_MUX_READBACK = 4'b1000
  } pscl_mux_t;

endpackage

// ### pscl_top.sv
`timescale 1ns/10ps
`include "pscl_defs.svh"
// How it works
// - Host sends 32-bit words MSB first; one bit shifted per serial clock rise.
// - Load strobe rising edge copies the word into the register selected by DB3..DB0.
// - Select bits decode as binary register number, zero to thirteen.
// - Double-buffered settings wait pending until a later register 0 write.
// - Host writes buffered register first; frequency change starts on register 0.
// - Register 0 bit 28 picks fixed or variable modulus modulator.
// - Fraction word comes from register 1 bits 28 to 4.
// - Aux numerator and denominator come from registers 3 and 4 bits 27..4.
// - Half-step offset present unless register 5 bit 24 cancels it.
// - Reference count 1..32 plus doubler and halver set comparison rate.
// - Register 12 selects test output source; o_test_output low while chip disabled, o_test_readback clears at the next serial clock rise.
// - Lock measurement every comparison cycle, or every 32nd when rate bit low.
// - In-window measurements count up; lock at target without oversize or slip.
// - Once locked, a cycle slip declares loss of lock.
// - Test output shows lock state when lock detect is selected.
// - Lock window from register 6 bits 9..8 and register 9 bits 31..30.
// - Lock target spans 2 to 8192; slow rate needs at least 64 cycles.
// - Readback shifts previous register value out while new word shifts in.
// - Readback mode code 1000; register 12 bits 19..14 pick readback source.
// - Chip disabled powers down, three-states pump, clears all registers.
// - Lock detect pin high while the detector reports lock.
module pscl_top (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ser_clk,
  input  wire logic        i_ser_data,
  input  wire logic        i_load_strobe,
  input  wire logic        i_chip_enable,
  input  wire logic        i_cmp_cycle,
  input  wire logic        i_pulse_in_window,
  input  wire logic        i_cycle_slip,
  output logic             o_test_output,
  output logic             o_test_readback,
  output logic             o_lock_detect_pin,
  output logic             o_power_down,
  output logic             o_pump_tristate,
  output logic             o_freq_change,
  output logic             o_var_modulus,
  output logic [15:0]      o_int_value,
  output logic [24:0]      o_fraction_word,
  output logic [23:0]      o_aux_numerator,
  output logic [23:0]      o_aux_denominator,
  output logic             o_half_step_cancel,
  output logic [5:0]       o_ref_ratio,
  output logic             o_ref_doubler,
  output logic             o_ref_halver,
  output logic [3:0]       o_pump_current,
  output logic [11:0]      o_resync_divider,
  output logic [3:0]       o_lock_window
);

  // ---------------- Serial clock domain ----------------
  logic [31:0] shift_word;
  logic [4:0]  bit_cnt;
  logic [31:0] rb_shift;
  logic [31:0] rb_word;
  logic        rb_mode;

  always_ff @(posedge i_ser_clk) begin
    shift_word <= {shift_word[30:0], i_ser_data};
  end

  // Frame position restarts whenever the load strobe is high
  always_ff @(posedge i_ser_clk or posedge i_load_strobe) begin
    if (i_load_strobe) begin
      bit_cnt <= 5'h00;
    end else begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // rb_word and rb_mode only change at a load, while the serial clock is
  // idle, so both cross quasi-static; a synchroniser on a stopped clock
  // would hold the stale mode into the first bits of the next frame
  always_ff @(posedge i_ser_clk) begin
    if (bit_cnt == 5'h00) begin
      rb_shift        <= {rb_word[30:0], 1'b0};
      o_test_readback <= rb_mode & rb_word[31];
    end else begin
      rb_shift        <= {rb_shift[30:0], 1'b0};
      o_test_readback <= rb_mode & rb_shift[31];
    end
  end

  // ---------------- Core clock domain ----------------
  logic        le_s1;
  logic        le_s2;
  logic        le_s3;
  logic        ce_s1;
  logic        ce_s2;
  logic        load_pulse;
  logic [3:0]  sel;
  logic        sel_ok;
  logic [31:0] regs [0:`PSCL_REG_COUNT-1];
  logic [31:0] last_word;
  logic        commit;
  logic        locked;
  logic [12:0] lock_cnt;
  logic [13:0] lock_target;
  logic [4:0]  slow_cnt;
  logic        meas_en;
  logic [5:0]  rb_sel;
  pscl_pkg::pscl_mux_t mux_sel;

  always_ff @(posedge i_core_clk) begin
    le_s1 <= i_load_strobe;
    le_s2 <= le_s1;
    le_s3 <= le_s2;
    ce_s1 <= i_chip_enable;
    ce_s2 <= ce_s1;
  end

  assign load_pulse = le_s2 & ~le_s3 & ce_s2;
  assign sel        = shift_word[3:0];
  assign sel_ok     = (sel <= `PSCL_REG_LAST);
  assign commit     = load_pulse && (sel == `PSCL_REG_INT);

  genvar g;
  generate
    for (g = 0; g < `PSCL_REG_COUNT; g = g + 1) begin : g_reg
      always_ff @(posedge i_core_clk) begin
        if (i_rst || !ce_s2) begin
          regs[g] <= `PSCL_WORD_RESET;
        end else if (load_pulse && sel_ok && (sel == 4'(g))) begin
          regs[g] <= shift_word;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk) begin
    if (i_rst || !ce_s2) begin
      last_word <= `PSCL_WORD_RESET;
    end else if (load_pulse && sel_ok) begin
      last_word <= shift_word;
    end
  end

  // Active settings; buffered ones follow pending copies on commit
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !ce_s2) begin
      o_var_modulus      <= 1'b0;
      o_int_value        <= 16'h0000;
      o_fraction_word    <= 25'h0000000;
      o_aux_numerator    <= 24'h000000;
      o_aux_denominator  <= 24'h000000;
      o_ref_ratio        <= 6'h20;
      o_ref_doubler      <= 1'b0;
      o_ref_halver       <= 1'b0;
      o_pump_current     <= 4'h0;
      o_resync_divider   <= 12'h000;
    end else if (commit) begin
      o_var_modulus     <= shift_word[`PSCL_VARMOD_BIT];
      o_int_value       <= shift_word[`PSCL_INT_MSB:`PSCL_INT_LSB];
      o_fraction_word   <=
        regs[`PSCL_REG_FRAC][`PSCL_FRAC_MSB:`PSCL_FRAC_LSB];
      o_aux_numerator   <=
        regs[`PSCL_REG_AUXNUM][`PSCL_AUX_MSB:`PSCL_AUX_LSB];
      o_aux_denominator <=
        regs[`PSCL_REG_AUXDEN][`PSCL_AUX_MSB:`PSCL_AUX_LSB];
      // Count code zero means divide by 32
      o_ref_ratio <= (regs[`PSCL_REG_REFDIV][`PSCL_RCNT_MSB:`PSCL_RCNT_LSB]
                      == 5'h00) ? 6'h20 :
                     {1'b0, regs[`PSCL_REG_REFDIV]
                            [`PSCL_RCNT_MSB:`PSCL_RCNT_LSB]};
      o_ref_doubler   <= regs[`PSCL_REG_REFDIV][`PSCL_DOUBLER_BIT];
      o_ref_halver    <= regs[`PSCL_REG_REFDIV][`PSCL_HALVER_BIT];
      o_pump_current  <= regs[`PSCL_REG_REFDIV][`PSCL_CPI_MSB:`PSCL_CPI_LSB];
      o_resync_divider <=
        regs[`PSCL_REG_REFDIV][`PSCL_RESYNC_MSB:`PSCL_RESYNC_LSB];
    end
  end

  // Immediate settings
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !ce_s2) begin
      o_half_step_cancel <= 1'b0;
      o_lock_window      <= 4'h0;
      o_freq_change      <= 1'b0;
      o_power_down       <= 1'b1;
      o_pump_tristate    <= 1'b1;
    end else begin
      o_half_step_cancel <= regs[`PSCL_REG_REFDIV][`PSCL_HALFCANCEL];
      o_lock_window <= {regs[`PSCL_REG_LDBIAS]
                            [`PSCL_WINBIAS_MSB:`PSCL_WINBIAS_LSB],
                        regs[`PSCL_REG_FUNC]
                            [`PSCL_WINSEL_MSB:`PSCL_WINSEL_LSB]};
      o_freq_change      <= commit;
      o_power_down       <= 1'b0;
      o_pump_tristate    <= 1'b0;
    end
  end

  // Lock count target table, 2 up to 8192
  always_comb begin
    unique case (regs[`PSCL_REG_CLK2][`PSCL_LDCNT_MSB:`PSCL_LDCNT_LSB])
      3'h0: lock_target = 14'd2;
      3'h1: lock_target = 14'd4;
      3'h2: lock_target = 14'd16;
      3'h3: lock_target = 14'd64;
      3'h4: lock_target = 14'd256;
      3'h5: lock_target = 14'd1024;
      3'h6: lock_target = 14'd4096;
      3'h7: lock_target = 14'd8192;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst || !ce_s2) begin
      slow_cnt <= 5'h00;
    end else if (i_cmp_cycle) begin
      slow_cnt <= slow_cnt + 5'h01;
    end
  end

  assign meas_en = i_cmp_cycle &&
                   (regs[`PSCL_REG_CLK2][`PSCL_LDRATE_BIT] ||
                    (slow_cnt == `PSCL_SLOW_DIV));

  always_ff @(posedge i_core_clk) begin
    if (i_rst || !ce_s2) begin
      lock_cnt <= 13'h0000;
      locked   <= 1'b0;
    end else if (meas_en) begin
      if (i_cycle_slip) begin
        lock_cnt <= 13'h0000;
        locked   <= 1'b0;
      end else if (!locked) begin
        if (!i_pulse_in_window) begin
          lock_cnt <= 13'h0000;
        end else if ({1'b0, lock_cnt} + 14'd1 >= lock_target) begin
          locked   <= 1'b1;
        end else begin
          lock_cnt <= lock_cnt + 13'h0001;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst || !ce_s2) begin
      o_lock_detect_pin <= 1'b0;
    end else begin
      o_lock_detect_pin <= locked;
    end
  end

  assign mux_sel = pscl_pkg::pscl_mux_t'(
    regs[`PSCL_REG_MUXRB][`PSCL_MUXSEL_MSB:`PSCL_MUXSEL_LSB]);
  assign rb_sel  = regs[`PSCL_REG_MUXRB][`PSCL_RBSEL_MSB:`PSCL_RBSEL_LSB];

  always_ff @(posedge i_core_clk) begin
    if (i_rst || !ce_s2) begin
      o_test_output <= 1'b0;
      rb_mode       <= 1'b0;
    end else begin
      rb_mode <= (mux_sel == pscl_pkg::PSCL_MUX_READBACK);
      case (mux_sel)
        pscl_pkg::PSCL_MUX_HIGH: o_test_output <= 1'b1;
        pscl_pkg::PSCL_MUX_LOCK: o_test_output <= locked;
        default:                 o_test_output <= 1'b0;
      endcase
    end
  end

  // Readback source
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !ce_s2) begin
      rb_word <= `PSCL_WORD_RESET;
    end else if (rb_sel == `PSCL_RB_REVSEL) begin
      rb_word <= `PSCL_REV_CODE;
    end else if (rb_sel == `PSCL_RB_PATSEL) begin
      rb_word <= `PSCL_RB_PATTERN;
    end else if (rb_sel <= {2'b00, `PSCL_REG_LAST} && rb_sel != 6'h00) begin
      rb_word <= regs[rb_sel[3:0]];
    end else begin
      rb_word <= last_word;
    end
  end

  // ---------------- Checks ----------------
  a_load_copy: assert property (@(posedge i_core_clk) disable iff (i_rst)
    load_pulse && sel == `PSCL_REG_FUNC |=>
      regs[`PSCL_REG_FUNC] == $past(shift_word))
    else $error("selected register not loaded");

  a_bad_sel_ignored: assert property (@(posedge i_core_clk)
    disable iff (i_rst) load_pulse && !sel_ok |=> $stable(last_word))
    else $error("illegal select changed state");

  a_pending_hold: assert property (@(posedge i_core_clk)
    disable iff (i_rst) ce_s2 && !commit |=> $stable(o_fraction_word))
    else $error("fraction changed without commit");

  a_commit_frac: assert property (@(posedge i_core_clk)
    disable iff (i_rst) commit && ce_s2 |=>
      o_fraction_word == $past(regs[`PSCL_REG_FRAC][28:4])
      && o_freq_change)
    else $error("commit did not apply fraction");

  a_disable_low: assert property (@(posedge i_core_clk)
    disable iff (i_rst) !ce_s2 |=> !o_test_output && o_pump_tristate)
    else $error("outputs active while disabled");

  a_lock_pins: assert property (@(posedge i_core_clk)
    disable iff (i_rst) ce_s2 && $past(ce_s2) |->
      o_lock_detect_pin == $past(locked))
    else $error("lock pin mismatch");

  a_slip_unlock: assert property (@(posedge i_core_clk)
    disable iff (i_rst) meas_en && i_cycle_slip |=> !locked ##1
      !o_lock_detect_pin)
    else $error("slip did not drop lock");

  a_lock_needs_meas: assert property (@(posedge i_core_clk)
    disable iff (i_rst) !locked && !meas_en |=> !locked)
    else $error("lock without measurement");

  a_slow_rate: assert property (@(posedge i_core_clk)
    disable iff (i_rst) meas_en && !regs[`PSCL_REG_CLK2][26] |->
      slow_cnt == 5'h1F)
    else $error("slow rate measured off slot");

  a_freq_only_commit: assert property (@(posedge i_core_clk)
    disable iff (i_rst) ce_s2 && !commit |=> !o_freq_change)
    else $error("frequency change without register 0 write");

  a_window_follow: assert property (@(posedge i_core_clk)
    disable iff (i_rst) ce_s2 |=>
      o_lock_window == {$past(regs[`PSCL_REG_LDBIAS][31:30]),
                        $past(regs[`PSCL_REG_FUNC][9:8])})
    else $error("lock window not taken from its fields");

endmodule
